// ---- verilog/gst_timer.sv ----
/*
  Gated sixteen-bit timer/counter with a classic Wishbone register slave.
  Assumes all inputs synchronous to clk_i; registers sit in data bits 7:0.
*/
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [R1] sixteen-bit up-counter as two eight-bit bytes, timer or event counter
// [R2] special event trigger from the capture unit clears the count
// [R3] software avoids the system clock when serving capture or compare
// [R4] clock source: instruction clock, system clock, external, internal oscillator
// [R5] prescaler divides the chosen clock by 1, 2, 4 or 8
// [R6] oscillator enable picks oscillator or count pin for external source
// [R7] sync bypass bit acts only with the external source
// [R8] wide access bit picks sixteen-bit or two eight-bit accesses
// [R9] wide mode: low byte read copies true high byte into buffer
// [R10] wide mode: high write loads buffer, low write commits both bytes
// [R11] run bit starts and stops counting
// [R12] gate enable makes counting depend on gate while running
// [R13] gate polarity chooses active high or active low
// [R14] toggle flip-flop held clear while toggle mode is off
// [R15] toggle flip-flop inverts on each rising gate edge
// [R16] single-pulse mode bit lets pulse acquisition control the gate
// [R17] go bit reads one while armed, zero when done or idle
// [R18] clearing single-pulse mode clears the go bit
// [R19] go bit clears on captured pulse trailing edge; no more counting
// [R20] gate level status shows the gate regardless of gate enable
// [R21] gate source: gate pin, period match, comparator 1, comparator 2
// [R22] overflow flag set when the count wraps to zero
module gst_timer #(
  parameter int ADR_W = 8                     // wishbone byte address width
) (
  input wire logic clk_i,                     // system clock, 10 MHz
  input wire logic rst_i,                     // synchronous reset, active high
  input wire logic wb_cyc_i,                  // wishbone cycle
  input wire logic wb_stb_i,                  // wishbone strobe
  input wire logic wb_we_i,                   // wishbone write enable
  input wire logic [ADR_W-1:0] wb_adr_i,      // wishbone byte address
  input wire logic [3:0] wb_sel_i,            // wishbone byte selects
  input wire logic [31:0] wb_dat_i,           // wishbone write data
  output logic [31:0] wb_dat_o,               // wishbone read data
  output logic wb_ack_o,                      // wishbone acknowledge
  input wire logic external_count_input_i,    // external count pin
  input wire logic secondary_oscillator_i,    // secondary oscillator clock
  input wire logic internal_oscillator_i,     // internal oscillator clock
  input wire logic special_event_i,           // capture unit special event trigger
  input wire gst_pkg::gst_gsrc_t gate_src_i,  // gate sources
  output logic [15:0] count_o,                // live count
  output logic overflow_o,                    // sticky overflow flag
  output logic gate_level_o,                  // registered gate level
  output logic secondary_osc_on_o             // secondary oscillator request
);
  gst_pkg::gst_st_t q;
  gst_pkg::gst_st_t n;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] wd;
  logic wr_ctrl;
  logic wr_gctrl;
  logic wr_low;
  logic wr_high;
  logic wr_stat;
  logic rd_low;
  logic ext_src;
  logic ext_tick;
  logic src_tick;
  logic [2:0] psc_last;
  logic allow;
  logic inc;
  logic ovf_set;
  logic wr_cnt;
  logic gate_lvl;
  logic gate_done;

  // gate path lives in its own module
  gst_gate u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .gctrl_i(q.gctrl),
    .gsrc_i(gate_src_i),
    .level_o(gate_lvl),
    .done_o(gate_done)
  );

  // bus decode: one access per request, answered one cycle later
  always_comb
  begin
    acc = wb_cyc_i && wb_stb_i && !q.ack;
    wr = acc && wb_we_i && wb_sel_i[0];
    rd = acc && !wb_we_i;
    wd = wb_dat_i[7:0];
    wr_ctrl = wr && (wb_adr_i == gst_pkg::GST_OFS_CTRL);
    wr_gctrl = wr && (wb_adr_i == gst_pkg::GST_OFS_GCTRL);
    wr_low = wr && (wb_adr_i == gst_pkg::GST_OFS_CLOW);
    wr_high = wr && (wb_adr_i == gst_pkg::GST_OFS_CHIGH);
    wr_stat = wr && (wb_adr_i == gst_pkg::GST_OFS_STAT);
    rd_low = rd && (wb_adr_i == gst_pkg::GST_OFS_CLOW);
    wr_cnt = wr_low || (wr_high && !q.ctrl.wide_access_enable);
  end

  // count source, prescaler and gate qualification
  always_comb
  begin
    // [R6] oscillator or pin for the external source
    ext_src = q.ctrl.secondary_osc_enable ? secondary_oscillator_i : external_count_input_i;
    // [R7] bypass uses the raw edge, else the two-stage synchroniser
    ext_tick = q.ctrl.ext_input_sync_bypass ? (ext_src && !q.ext_prev) : (q.ext_s2 && !q.ext_s3);
    // [R4] increment source select
    case (q.ctrl.clock_source_select)
      gst_pkg::GST_CS_ICLK: src_tick = (q.idiv == gst_pkg::GST_ICLK_LAST);
      gst_pkg::GST_CS_SYS: src_tick = 1'b1;
      gst_pkg::GST_CS_EXT: src_tick = ext_tick;
      default: src_tick = internal_oscillator_i && !q.iosc_prev;
    endcase
    // [R5] terminal prescaler count per ratio
    case (q.ctrl.input_prescale_select)
      2'h0: psc_last = 3'h0;
      2'h1: psc_last = 3'h1;
      2'h2: psc_last = 3'h3;
      default: psc_last = 3'h7;
    endcase
    // [R12] gate only matters when enabled
    allow = !q.gctrl.gate_enable || gate_lvl;
    // [R11] run bit gates the whole count path
    inc = q.ctrl.timer_run && src_tick && (q.psc >= psc_last) && allow;
    // [R22] wrap from all ones
    ovf_set = inc && (q.count == gst_pkg::GST_COUNT_MAX);
  end

  // next-state of the whole block
  always_comb
  begin
    n = q;
    n.ack = acc;
    n.idiv = q.idiv + 2'h1;
    // synchroniser stages; the first is read only by the second
    n.ext_s1 = ext_src;
    n.ext_s2 = q.ext_s1;
    n.ext_s3 = q.ext_s2;
    n.ext_prev = ext_src;
    n.iosc_prev = internal_oscillator_i;
    n.level = gate_lvl;
    // [R5] prescaler advances on source ticks while running
    if (q.ctrl.timer_run && src_tick)
      n.psc = (q.psc >= psc_last) ? 3'h0 : q.psc + 3'h1; // a count left above a smaller new ratio ends at once
    // [R1] count up
    if (inc)
      n.count = q.count + 16'h0001;
    // [R2] special event clears count and prescaler
    if (special_event_i)
    begin
      n.count = gst_pkg::GST_COUNT_RST;
      n.psc = 3'h0;
    end
    // [R22] sticky flag, the set wins over a write-one clear
    n.ovf = ovf_set || (q.ovf && !(wr_stat && wd[gst_pkg::GST_STAT_OVF_BIT]));
    // [R19] trailing edge of captured pulse ends acquisition
    if (gate_done)
      n.gctrl.pulse_acquire_go = 1'b0;
    if (wr_ctrl)
      n.ctrl = gst_pkg::gst_ctrl_t'(wd);
    if (wr_gctrl)
    begin
      n.gctrl = gst_pkg::gst_gctrl_t'(wd);
      n.gctrl.gate_level = 1'b0;
    end
    // [R18] go bit cannot stand without single-pulse mode
    if (!n.gctrl.gate_single_pulse_mode)
      n.gctrl.pulse_acquire_go = 1'b0;
    // [R10] low write commits buffered high byte in wide mode
    if (wr_low)
    begin
      n.count[7:0] = wd;
      n.psc = 3'h0;
      if (q.ctrl.wide_access_enable)
        n.count[15:8] = q.hbuf;
    end
    // [R8] high write: buffer in wide mode, true byte otherwise
    if (wr_high)
    begin
      if (q.ctrl.wide_access_enable)
        n.hbuf = wd;
      else
        n.count[15:8] = wd;
    end
    // [R9] low read snapshots the true high byte
    if (rd_low && q.ctrl.wide_access_enable)
      n.hbuf = q.count[15:8];
    // read data is registered with the acknowledge
    n.dat = 8'h00;
    if (rd)
    begin
      case (wb_adr_i)
        gst_pkg::GST_OFS_CTRL: n.dat = q.ctrl;
        // [R17] go bit shows armed state, level shows gate
        gst_pkg::GST_OFS_GCTRL: n.dat = {q.gctrl[7:3], q.level, q.gctrl[1:0]};
        gst_pkg::GST_OFS_CLOW: n.dat = q.count[7:0];
        gst_pkg::GST_OFS_CHIGH: n.dat = q.ctrl.wide_access_enable ? q.hbuf : q.count[15:8];
        gst_pkg::GST_OFS_STAT: n.dat = {7'h00, q.ovf};
        default: n.dat = 8'h00;
      endcase
    end
  end

  // single state register; a synchronous reset loads constants only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.ctrl <= gst_pkg::gst_ctrl_t'(gst_pkg::GST_CTRL_RST);
      q.gctrl <= gst_pkg::gst_gctrl_t'(gst_pkg::GST_GCTRL_RST);
      q.count <= gst_pkg::GST_COUNT_RST;
    end
    else
      q <= n;
  end

  // outputs straight from the state register
  assign wb_dat_o = {24'h00_0000, q.dat};
  assign wb_ack_o = q.ack;
  assign count_o = q.count;
  assign overflow_o = q.ovf;
  assign gate_level_o = q.level;
  assign secondary_osc_on_o = q.ctrl.secondary_osc_enable;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_run_stop;
    !q.ctrl.timer_run && !wr_cnt && !special_event_i |=> $stable(q.count);
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("count moved while stopped"); // [R11]
  property p_event_clear;
    special_event_i && !wr_cnt |=> q.count == 16'h0000;
  endproperty
  a_event_clear: assert property (p_event_clear) else $error("special event did not clear count"); // [R2]
  property p_overflow;
    q.ctrl.timer_run && inc && q.count == 16'hFFFF |=> q.ovf && q.count == 16'h0000;
  endproperty
  a_overflow: assert property (p_overflow) else $error("wrap did not set overflow flag"); // [R22]
  property p_sysclk_rate;
    q.ctrl.timer_run && q.ctrl.clock_source_select == 2'h1 && q.ctrl.input_prescale_select == 2'h0
      && !q.gctrl.gate_enable && !wr_cnt && !special_event_i |=> q.count == $past(q.count) + 16'h0001;
  endproperty
  a_sysclk_rate: assert property (p_sysclk_rate) else $error("system clock 1:1 count missed"); // [R5]
  property p_iclk_rate;
    q.ctrl.timer_run && q.ctrl.clock_source_select == 2'h0 && q.ctrl.input_prescale_select == 2'h0
      && !q.gctrl.gate_enable && !wr_cnt && !special_event_i && !wr_ctrl && !wr_gctrl && q.count != 16'hFFFF
      ##1 !wr_cnt && !special_event_i && !wr_ctrl && !wr_gctrl
      ##1 !wr_cnt && !special_event_i && !wr_ctrl && !wr_gctrl
      ##1 !wr_cnt && !special_event_i
      |=> q.count == $past(q.count, 4) + 16'h0001;
  endproperty
  a_iclk_rate: assert property (p_iclk_rate) else $error("instruction clock rate wrong"); // [R4]
  property p_wide_read;
    rd_low && q.ctrl.wide_access_enable |=> q.hbuf == $past(q.count[15:8]);
  endproperty
  a_wide_read: assert property (p_wide_read) else $error("low read did not latch high byte"); // [R9]
  property p_wide_write;
    wr_low && q.ctrl.wide_access_enable |=> q.count == {$past(q.hbuf), $past(wd)};
  endproperty
  a_wide_write: assert property (p_wide_write) else $error("low write did not commit buffer"); // [R10]
  property p_spm_go;
    !q.gctrl.gate_single_pulse_mode |-> !q.gctrl.pulse_acquire_go;
  endproperty
  a_spm_go: assert property (p_spm_go) else $error("go bit set without single-pulse mode"); // [R18]
  property p_done_clear;
    gate_done && !wr_gctrl |=> !q.gctrl.pulse_acquire_go;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("go bit not cleared at pulse end"); // [R19]

  c_overflow: cover property (ovf_set);
  c_event: cover property (special_event_i && q.count != 16'h0000);
  c_pulse_done: cover property (gate_done);
  c_wide_read: cover property (rd_low && q.ctrl.wide_access_enable);
endmodule
`default_nettype wire

// ---- shared/gst_pkg.sv ----
/*
  Package for the gated sixteen-bit timer: register offsets, reset values,
  selector codes and the packed structs that carry control and state.
  Assumes a classic Wishbone slave with 32-bit data, registers in the low byte.
*/
package gst_pkg;
  // register byte offsets
  localparam logic [7:0] GST_OFS_CTRL = 8'h00;
  localparam logic [7:0] GST_OFS_GCTRL = 8'h04;
  localparam logic [7:0] GST_OFS_CLOW = 8'h08;
  localparam logic [7:0] GST_OFS_CHIGH = 8'h0C;
  localparam logic [7:0] GST_OFS_STAT = 8'h10;
  // values after reset, and the top value of the count
  localparam logic [7:0] GST_CTRL_RST = 8'h00;
  localparam logic [7:0] GST_GCTRL_RST = 8'h00;
  localparam logic [15:0] GST_COUNT_RST = 16'h0000;
  localparam logic [15:0] GST_COUNT_MAX = 16'hFFFF;
  // status field position
  localparam int GST_STAT_OVF_BIT = 0;
  // instruction clock is the system clock divided by four
  localparam logic [1:0] GST_ICLK_LAST = 2'h3;
  // clock source codes
  localparam logic [1:0] GST_CS_ICLK = 2'h0;
  localparam logic [1:0] GST_CS_SYS = 2'h1;
  localparam logic [1:0] GST_CS_EXT = 2'h2;
  localparam logic [1:0] GST_CS_IOSC = 2'h3;
  // gate source codes
  localparam logic [1:0] GST_GS_PIN = 2'h0;
  localparam logic [1:0] GST_GS_PMATCH = 2'h1;
  localparam logic [1:0] GST_GS_CMP1 = 2'h2;
  localparam logic [1:0] GST_GS_CMP2 = 2'h3;

  typedef struct packed {
    logic [1:0] clock_source_select;
    logic [1:0] input_prescale_select;
    logic secondary_osc_enable;
    logic ext_input_sync_bypass;
    logic wide_access_enable;
    logic timer_run;
  } gst_ctrl_t;

  typedef struct packed {
    logic gate_enable;
    logic gate_polarity;
    logic gate_toggle_mode;
    logic gate_single_pulse_mode;
    logic pulse_acquire_go;
    logic gate_level;
    logic [1:0] gate_source_select;
  } gst_gctrl_t;

  typedef struct packed {
    logic gate_pin;
    logic period_match;
    logic cmp1;
    logic cmp2;
  } gst_gsrc_t;

  typedef struct packed {
    logic act_prev;
    logic tff;
    logic tv_prev;
    logic sp_run;
  } gst_gate_st_t;

  typedef struct packed {
    logic ack;
    logic [7:0] dat;
    gst_ctrl_t ctrl;
    gst_gctrl_t gctrl;
    logic [15:0] count;
    logic [7:0] hbuf;
    logic [2:0] psc;
    logic [1:0] idiv;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_prev;
    logic iosc_prev;
    logic ovf;
    logic level;
  } gst_st_t;
endpackage

// ---- verilog/gst_gate.sv ----
/*
  Gate logic of the timer: source select, polarity, toggle flip-flop and
  single-pulse acquisition. Gate sources are synchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module gst_gate (
  input wire logic clk_i,                      // system clock
  input wire logic rst_i,                      // synchronous reset
  input wire gst_pkg::gst_gctrl_t gctrl_i,     // gate control fields
  input wire gst_pkg::gst_gsrc_t gsrc_i,       // gate source inputs
  output logic level_o,                        // gate state that could feed the count
  output logic done_o                          // trailing edge of captured pulse
);
  gst_pkg::gst_gate_st_t q;
  gst_pkg::gst_gate_st_t n;
  logic raw;
  logic act;
  logic tv;

  // select, polarise, toggle and single-pulse gating
  always_comb
  begin
    n = q;
    // [R21] gate source mux
    case (gctrl_i.gate_source_select)
      gst_pkg::GST_GS_PIN: raw = gsrc_i.gate_pin;
      gst_pkg::GST_GS_PMATCH: raw = gsrc_i.period_match;
      gst_pkg::GST_GS_CMP1: raw = gsrc_i.cmp1;
      default: raw = gsrc_i.cmp2;
    endcase
    // [R13] polarity select
    act = gctrl_i.gate_polarity ? raw : !raw;
    n.act_prev = act;
    // [R14] toggle held clear
    if (!gctrl_i.gate_toggle_mode)
      n.tff = 1'b0;
    // [R15] invert on rising edge
    else if (act && !q.act_prev)
      n.tff = !q.tff;
    tv = gctrl_i.gate_toggle_mode ? q.tff : act;
    n.tv_prev = tv;
    done_o = 1'b0;
    // [R16] single pulse arms on rising edge, ends on trailing edge
    if (!gctrl_i.gate_single_pulse_mode || !gctrl_i.pulse_acquire_go)
      n.sp_run = 1'b0;
    else if (!q.sp_run && tv && !q.tv_prev)
      n.sp_run = 1'b1;
    else if (q.sp_run && !tv)
    begin
      n.sp_run = 1'b0;
      done_o = 1'b1;
    end
    // [R20] level ignores gate enable
    level_o = gctrl_i.gate_single_pulse_mode ? (q.sp_run && tv) : tv;
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= n;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_toggle_clear;
    !gctrl_i.gate_toggle_mode |=> !q.tff;
  endproperty
  a_toggle_clear: assert property (p_toggle_clear) else $error("toggle flop not held clear"); // [R14]
  property p_polarity;
    !gctrl_i.gate_toggle_mode && !gctrl_i.gate_single_pulse_mode |-> level_o == (raw ~^ gctrl_i.gate_polarity);
  endproperty
  a_polarity: assert property (p_polarity) else $error("gate level ignores polarity"); // [R13]
  property p_toggle_flip;
    gctrl_i.gate_toggle_mode && act && !q.act_prev ##1 gctrl_i.gate_toggle_mode |-> q.tff != $past(q.tff);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("toggle flop missed an edge"); // [R15]
endmodule
`default_nettype wire

// ---- tb/gst_far_side.sv ----
/*
  Far-side model: count pin, oscillators, comparators and companion timer.
  Assumes the bench sets the wanted gate levels just after a rising clk_i edge.
*/
`timescale 1ns/1ns
`default_nettype none
module gst_far_side (
  input wire logic clk_i,                 // system clock
  input wire logic rst_i,                 // synchronous reset
  input wire gst_pkg::gst_gsrc_t want_i,  // wanted gate source levels
  output gst_pkg::gst_gsrc_t gsrc_o,      // gate sources to the timer
  output logic ext_o,                     // count pin, rising every 4 clocks
  output logic secondary_oscillator_o,                    // secondary oscillator, rising every 8
  output logic iosc_o                     // internal oscillator, rising every 2
);
  logic [2:0] ph_q;
  logic pm_q;

  // oscillators run free, as real ones do between tests
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ph_q <= 3'h0;
      pm_q <= 1'b0;
      gsrc_o <= '0;
    end
    else
    begin
      ph_q <= ph_q + 3'h1;
      pm_q <= want_i.period_match;
      // companion match is a one-cycle pulse, never a level
      gsrc_o <= gst_pkg::gst_gsrc_t'({want_i.gate_pin, want_i.period_match & ~pm_q, want_i.cmp1, want_i.cmp2});
    end
  end

  // clock-like outputs decoded from one phase counter
  assign iosc_o = ph_q[0];
  assign ext_o = ph_q[1];
  assign secondary_oscillator_o = ph_q[2];
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the gated sixteen-bit timer.
  Assumes gst_far_side on the far side and a one-cycle Wishbone answer.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic se = 1'b0;
  gst_pkg::gst_gsrc_t want = '0;
  gst_pkg::gst_gsrc_t gsrc;
  logic ext;
  logic secondary_oscillator;
  logic iosc;
  logic [31:0] rdat;
  logic ack;
  logic ovf;
  logic lvl;
  logic secondary_oscillator_on;
  logic [15:0] cnt;
  logic [15:0] c0v;
  logic [31:0] expq[$];
  logic [7:0] lfsr_q = 8'h07;
  logic [7:0] h;
  logic [7:0] l;
  logic [7:0] r;
  logic lv;
  logic act;
  int error_cnt = 0;
  int checks_done = 0;
  // external, oscillator and stopped settings with their steps per 64 clocks
  // no capture unit here, so the system clock source is fair to use
  logic [7:0] ctab[7] = '{8'h81, 8'h85, 8'h95, 8'h89, 8'hC1, 8'hF1, 8'h40};
  logic [15:0] etab[7] = '{16'h0010, 16'h0010, 16'h0008, 16'h0008, 16'h0020, 16'h0004, 16'h0000};

  always #50 clk_i = ~clk_i;

  gst_timer u_gst_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_count_input_i(ext), .secondary_oscillator_i(secondary_oscillator), .internal_oscillator_i(iosc),
    .special_event_i(se), .gate_src_i(gsrc), .count_o(cnt), .overflow_o(ovf), .gate_level_o(lvl),
    .secondary_osc_on_o(secondary_oscillator_on));

  gst_far_side u_gst_far_side (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .gsrc_o(gsrc),
    .ext_o(ext), .secondary_oscillator_o(secondary_oscillator), .iosc_o(iosc));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    return lfsr_q;
  endfunction

  // one classic cycle, held until ack, then a cycle with the strobe low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      error_cnt++;
      stop_test();
    end
    else
    begin
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({24'h00_0000, e});
    bus(1'b0, a, 8'h00);
  endtask

  // count steps over a fixed 64-clock window once settled
  task automatic rate(input logic [15:0] e);
    logic [15:0] c0;
    repeat (8) @(posedge clk_i);
    #1 c0 = cnt;
    repeat (64) @(posedge clk_i);
    #1 chk("count step", 16'(cnt - c0), {16'h0000, e});
  endtask

  task automatic pulse(input int n);
    want <= gst_pkg::gst_gsrc_t'(4'h8);
    repeat (n) @(posedge clk_i);
    want <= '0;
  endtask

  // read answers are matched in order against the driver's notes
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0)
    begin
      if (expq.size() > 0)
        chk("read data", rdat, expq.pop_front());
      else
        chk("read note", 32'h0000_0000, 32'h0000_0001);
    end
  end

  // hang guard: a run this long is a failure
  initial
  begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(gst_pkg::GST_OFS_CTRL, gst_pkg::GST_CTRL_RST);
    // low pin with active-low polarity is an active gate, so the level bit reads one
    rd(gst_pkg::GST_OFS_GCTRL, gst_pkg::GST_GCTRL_RST | 8'h04);
    rd(gst_pkg::GST_OFS_CLOW, 8'h00);
    rd(gst_pkg::GST_OFS_CHIGH, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    rd(gst_pkg::GST_OFS_CTRL, 8'h00);
    $display("test reset done");
    // instruction and system clock at every prescale
    for (int cs = 0; cs < 2; cs++)
      for (int ps = 0; ps < 4; ps++)
      begin
        wr(gst_pkg::GST_OFS_CTRL, {cs[1:0], ps[1:0], 4'h1});
        rate(16'((cs ? 64 : 16) >> ps));
      end
    for (int i = 0; i < 7; i++)
    begin
      wr(gst_pkg::GST_OFS_CTRL, ctab[i]);
      rate(etab[i]);
      chk("osc request", {31'h0, secondary_oscillator_on}, {31'h0, ctab[i][3]});
    end
    $display("test sources done");
    // wide access through the high-byte buffer
    wr(gst_pkg::GST_OFS_CTRL, 8'h02);
    h = rnd();
    l = rnd();
    wr(gst_pkg::GST_OFS_CHIGH, h);
    wr(gst_pkg::GST_OFS_CLOW, l);
    chk("wide write", {16'h0000, cnt}, {16'h0000, h, l});
    wr(gst_pkg::GST_OFS_CHIGH, ~h);
    chk("odd high", {16'h0000, cnt}, {16'h0000, h, l});
    rd(gst_pkg::GST_OFS_CLOW, l);
    rd(gst_pkg::GST_OFS_CHIGH, h);
    wr(gst_pkg::GST_OFS_CTRL, 8'h00);
    wr(gst_pkg::GST_OFS_CHIGH, 8'h5A);
    chk("byte write", {16'h0000, cnt}, {16'h0000, 8'h5A, l});
    rd(gst_pkg::GST_OFS_CHIGH, 8'h5A);
    $display("test access done");
    // wrap from the top, then write-one clear
    wr(gst_pkg::GST_OFS_CTRL, 8'h02);
    wr(gst_pkg::GST_OFS_CHIGH, 8'hFF);
    wr(gst_pkg::GST_OFS_CLOW, 8'hFE);
    wr(gst_pkg::GST_OFS_CTRL, 8'h43);
    wr(gst_pkg::GST_OFS_CTRL, 8'h02);
    chk("overflow", {31'h0, ovf}, 32'h0000_0001);
    rd(gst_pkg::GST_OFS_STAT, 8'h01);
    wr(gst_pkg::GST_OFS_STAT, 8'h01);
    rd(gst_pkg::GST_OFS_STAT, 8'h00);
    wr(gst_pkg::GST_OFS_CLOW, 8'h77);
    se <= 1'b1;
    @(posedge clk_i);
    se <= 1'b0;
    @(posedge clk_i);
    #1 chk("event clear", {16'h0000, cnt}, 32'h0000_0000);
    $display("test overflow done");
    // every gate source and polarity, levels drawn at random except period match, held low
    wr(gst_pkg::GST_OFS_CTRL, 8'h41);
    for (int g = 0; g < 4; g++)
      for (int p = 0; p < 2; p++)
      begin
        r = rnd();
        lv = (g == 1) ? 1'b0 : r[0];
        act = (lv == p[0]);
        want <= gst_pkg::gst_gsrc_t'(lv ? (4'h8 >> g) : 4'h0);
        wr(gst_pkg::GST_OFS_GCTRL, {1'b1, p[0], 4'h0, g[1:0]});
        rate(act ? 16'h0040 : 16'h0000);
        rd(gst_pkg::GST_OFS_GCTRL, {1'b1, p[0], 3'h0, act, g[1:0]});
        chk("gate level", {31'h0, lvl}, {31'h0, act});
      end
    want <= gst_pkg::gst_gsrc_t'(4'h8);
    wr(gst_pkg::GST_OFS_GCTRL, 8'h00);
    rate(16'h0040);
    rd(gst_pkg::GST_OFS_GCTRL, 8'h00);
    wr(gst_pkg::GST_OFS_GCTRL, 8'h40);
    rd(gst_pkg::GST_OFS_GCTRL, 8'h44);
    $display("test gate done");
    // toggle flop flips per rising edge, cleared while mode is off
    want <= '0;
    wr(gst_pkg::GST_OFS_GCTRL, 8'hE0);
    for (int k = 1; k < 4; k++)
    begin
      pulse(2);
      repeat (4) @(posedge clk_i);
      chk("toggle", {31'h0, lvl}, {31'h0, k[0]});
    end
    wr(gst_pkg::GST_OFS_GCTRL, 8'hC0);
    wr(gst_pkg::GST_OFS_GCTRL, 8'hE0);
    repeat (4) @(posedge clk_i);
    chk("toggle clear", {31'h0, lvl}, 32'h0000_0000);
    $display("test toggle done");
    // one pulse captured, the next ignored
    wr(gst_pkg::GST_OFS_GCTRL, 8'hD8);
    rd(gst_pkg::GST_OFS_GCTRL, 8'hD8);
    c0v = cnt;
    pulse(5);
    repeat (6) @(posedge clk_i);
    rd(gst_pkg::GST_OFS_GCTRL, 8'hD0);
    chk("pulse counted", {31'h0, cnt !== c0v}, 32'h0000_0001);
    c0v = cnt;
    pulse(5);
    repeat (6) @(posedge clk_i);
    chk("no recount", {16'h0000, cnt}, {16'h0000, c0v});
    wr(gst_pkg::GST_OFS_GCTRL, 8'hD8);
    wr(gst_pkg::GST_OFS_GCTRL, 8'hC8);
    rd(gst_pkg::GST_OFS_GCTRL, 8'hC0);
    $display("test pulse done");
    stop_test();
  end
endmodule
`default_nettype wire
